/* File: pmt_pkg.sv */
// Constants and types shared by the pulse measurement and trigger timer.
//
// Summary of operation
// - Counter advances on one selected tick: f1, f2, f8, f32 or subclock/32.
// - Measure mode counts up, captures to reload and clears on each edge.
// - Channels 0 to 2 run while their start flag (bits 5 to 7) is 1.
// - Each measure edge requests an interrupt except the first after start.
// - Overflow in measure mode requests an interrupt and sets the overflow bit.
// - Overflow bit clears on a mode write after the next tick, while the start flag is 1.
// - Measure mode count reads return the captured reload value.
// - Count read is undefined until the second edge after start.
// - Measure mode count writes change neither reload nor counter.
// - Trigger mode exists on channels 0 and 1; one trigger, one down-count.
// - Trigger mode reloads on underflow and stops; clearing start flag stops too.
// - Triggers during a running trigger-mode count are ignored.
// - Trigger count starts only with start flag, trigger enable and a trigger.
// - Trigger source is channel 2 over/underflow or its frequency counter underflow.
// - Trigger mode divides by n+1 with n from 0 to ffff.
// - Each trigger-mode underflow requests an interrupt and starts a conversion.
// - Trigger-mode writes while stopped load reload and counter; while running, reload only.
// - Side-control register accepts writes only when protect release is 1.
// - Shutdown low clears output enable; cutoff gives hi-z, else general I/O.
// - Two-bit mode field selects timer, event, measure or trigger mode.
package pmt_pkg;
    localparam int          CNT_W          = 16;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam int          RUN_BIT_LO     = 5;
    // Mode register field layout.
    localparam int          MODE_LO        = 0;
    localparam int          MODE_HI        = 1;
    localparam int          MR_EDGE_BIT    = 2;
    localparam int          MR_OVF_BIT     = 3;
    localparam int          MR_SRC_LO      = 6;
    localparam int          MR_SRC_HI      = 7;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    // Count source selection, plus subclock when the extra bit is set.
    localparam logic [1:0]  SRC_F1         = 2'h0;
    localparam logic [1:0]  SRC_F2         = 2'h1;
    localparam logic [1:0]  SRC_F8         = 2'h2;
    localparam logic [1:0]  SRC_F32        = 2'h3;
    localparam int          PRESC_W        = 5;
    typedef enum logic [1:0] {PMT_TIMER, PMT_EVENT, PMT_MEASURE, PMT_ADTRIG} pmt_mode_e;
endpackage

/* File: pmt_tick.sv */
// Count source prescaler that yields one-cycle ticks at the selected rate.
`timescale 1ns/10ps
`default_nettype none
module pmt_tick
    import pmt_pkg::*;
(
    input  wire logic       clk,        // System clock.
    input  wire logic       rst_n,      // Asynchronous reset, active low.
    input  wire logic [1:0] src_sel,    // Main clock divider select.
    input  wire logic       use_sub,    // Use subclock divided by 32.
    input  wire logic       sub_tick,   // Subclock/32 pulse, synchronous.
    output logic            tick        // One-cycle count pulse.
);
    logic [PRESC_W-1:0] presc_r;
    logic               tick_nxt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            presc_r <= '0;
        else
            presc_r <= PRESC_W'(presc_r + 1'b1);
    end

    always_comb
    begin
        case (src_sel)
            SRC_F1:  tick_nxt = 1'b1;
            SRC_F2:  tick_nxt = (presc_r[0] == 1'b1);
            SRC_F8:  tick_nxt = (presc_r[2:0] == 3'h7);
            default: tick_nxt = (presc_r == 5'h1f);
        endcase
        if (use_sub)
            tick_nxt = sub_tick;
    end

    assign tick = tick_nxt;
endmodule
`default_nettype wire

/* File: pmt_top.sv */
// One 16-bit channel with pulse measurement and A/D trigger modes plus side control.
`timescale 1ns/10ps
`default_nettype none
module pmt_top
    import pmt_pkg::*;
#(
    parameter bit TRIG_CAPABLE = 1'b1   // Channels 0 and 1 only.
)
(
    input  wire logic             CLOCK,          // 25 MHz clock.
    input  wire logic             RST_N,          // Async reset, active low.
    input  wire logic [2:0]       COUNT_START,    // Count-start reg bits 7:5.
    input  wire logic [1:0]       CHAN_INDEX,     // Which start bit is ours.
    input  wire logic             MODE_WR,        // Mode register write strobe.
    input  wire logic [7:0]       MODE_WDATA,     // Mode register write data.
    input  wire logic             COUNT_WR,       // Count register write strobe.
    input  wire logic [15:0]      COUNT_WDATA,    // Count register write data.
    input  wire logic             SUB_TICK,       // Subclock/32 pulse.
    input  wire logic             USE_SUBCLOCK,   // Select subclock source.
    input  wire logic             MEASURE_PULSE,  // Measured pulse input.
    input  wire logic             CH2_OVF_UDF,    // Channel 2 over/underflow.
    input  wire logic             IRQ_FREQ_UDF,   // Frequency counter underflow.
    input  wire logic             PROTECT_REL,    // Write protect release bit.
    input  wire logic             SIDE_WR,        // Side-control write strobe.
    input  wire logic [2:0]       SIDE_WDATA,     // {cutoff, src sel, trig en}.
    input  wire logic             OUT_EN_WR,      // Output-enable write strobe.
    input  wire logic             OUT_EN_WDATA,   // Output-enable write value.
    input  wire logic             SHUTDOWN_N,     // Shutdown input, active low.
    output logic [15:0]           COUNT_RDATA,    // Count register read value.
    output logic [7:0]            MODE_RDATA,     // Mode register read value.
    output logic [2:0]            SIDE_RDATA,     // Side-control read value.
    output logic                  RESULT_VALID,   // Measurement read is defined.
    output logic                  IRQ,            // Interrupt request pulse.
    output logic                  ADC_START,      // A/D conversion start pulse.
    output logic                  RUNNING,        // Trigger count in progress.
    output logic                  OUT_EN,         // Three-phase output enable.
    output logic                  PHASE_HIZ,      // Phase pins high-impedance.
    output logic                  PHASE_GPIO      // Phase pins as general I/O.
);
    import pmt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0]       mode_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] reload_r;
    logic [CNT_W-1:0] rd_r;
    logic             run_r;
    logic             seen1_r;
    logic             seen2_r;
    logic             pulse_d_r;
    logic             ovf_tick_r;
    logic             irq_r;
    logic             adc_r;
    logic             trig_en_r;
    logic             trig_sel_r;
    logic             cutoff_r;
    logic             out_en_r;
    logic             hiz_r;
    logic             gpio_r;
    logic             tick;
    logic             flag;
    logic             flag_d_r;
    logic             rise;
    logic             fall;
    logic             meas_edge;
    logic             trig;
    logic             ovf;
    logic             udf;
    pmt_mode_e        mode;

    assign mode  = pmt_mode_e'(mode_r[MODE_HI:MODE_LO]);
    assign flag  = COUNT_START[CHAN_INDEX];
    assign rise  = MEASURE_PULSE & ~pulse_d_r;
    assign fall  = ~MEASURE_PULSE & pulse_d_r;
    // Period uses rising edges only; width measures between opposite edges.
    assign meas_edge = mode_r[MR_EDGE_BIT] ? (rise | fall) : rise;
    assign trig  = trig_sel_r ? IRQ_FREQ_UDF : CH2_OVF_UDF;
    assign ovf   = flag && mode == PMT_MEASURE && tick && !meas_edge && cnt_r == CNT_MAX;
    assign udf   = flag && mode == PMT_ADTRIG && run_r && tick && cnt_r == CNT_ZERO;

    pmt_tick u_tick
    (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .src_sel (mode_r[MR_SRC_HI:MR_SRC_LO]),
        .use_sub (USE_SUBCLOCK),
        .sub_tick(SUB_TICK),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Edge tracking.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pulse_d_r <= 1'b0;
            flag_d_r  <= 1'b0;
        end
        else
        begin
            pulse_d_r <= MEASURE_PULSE;
            flag_d_r  <= flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register with sticky overflow bit.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mode_r     <= MODE_RESET;
            ovf_tick_r <= 1'b0;
        end
        else
        begin
            if (MODE_WR)
                mode_r <= {MODE_WDATA[7:4], mode_r[MR_OVF_BIT], MODE_WDATA[2:0]};
            // The overflow bit is cleared only by a write after one more tick.
            if (MODE_WR && ovf_tick_r && flag && !ovf)
                mode_r[MR_OVF_BIT] <= 1'b0;
            if (ovf)
            begin
                mode_r[MR_OVF_BIT] <= 1'b1;
                ovf_tick_r         <= 1'b0;
            end
            else if (tick && mode_r[MR_OVF_BIT])
                ovf_tick_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, reload register and run state.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cnt_r    <= CNT_ZERO;
            reload_r <= CNT_ZERO;
            run_r    <= 1'b0;
            seen1_r  <= 1'b0;
            seen2_r  <= 1'b0;
        end
        else if (mode == PMT_MEASURE)
        begin
            run_r <= 1'b0;
            // Count register writes are discarded here.
            if (!flag)
            begin
                seen1_r <= 1'b0;
                seen2_r <= 1'b0;
                if (flag_d_r)
                    cnt_r <= CNT_ZERO;
            end
            else if (meas_edge)
            begin
                reload_r <= cnt_r;
                cnt_r    <= CNT_ZERO;
                seen1_r  <= 1'b1;
                seen2_r  <= seen1_r;
            end
            else if (tick)
                cnt_r <= CNT_W'(cnt_r + 1'b1);
        end
        else if (mode == PMT_ADTRIG && TRIG_CAPABLE)
        begin
            seen1_r <= 1'b0;
            seen2_r <= 1'b0;
            if (COUNT_WR)
            begin
                reload_r <= COUNT_WDATA;
                if (!run_r)
                    cnt_r <= COUNT_WDATA;
            end
            if (!flag)
                run_r <= 1'b0;
            else if (udf)
            begin
                cnt_r <= COUNT_WR ? COUNT_WDATA : reload_r;
                run_r <= 1'b0;
            end
            else if (!run_r && trig_en_r && trig)
                run_r <= 1'b1;
            else if (run_r && tick)
                cnt_r <= CNT_W'(cnt_r - 1'b1);
        end
        else
        begin
            run_r   <= 1'b0;
            seen1_r <= 1'b0;
            seen2_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt and conversion start pulses, read data.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_r <= 1'b0;
            adc_r <= 1'b0;
            rd_r  <= CNT_ZERO;
        end
        else
        begin
            irq_r <= ovf || udf
                  || (mode == PMT_MEASURE && flag && meas_edge && seen1_r);
            adc_r <= udf;
            rd_r  <= (mode == PMT_MEASURE) ? reload_r : cnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Side control, write protect and shutdown cutoff.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            trig_en_r  <= 1'b0;
            trig_sel_r <= 1'b0;
            cutoff_r   <= 1'b0;
            out_en_r   <= 1'b0;
            hiz_r      <= 1'b0;
            gpio_r     <= 1'b0;
        end
        else
        begin
            if (SIDE_WR && PROTECT_REL)
            begin
                trig_en_r  <= SIDE_WDATA[0];
                trig_sel_r <= SIDE_WDATA[1];
                cutoff_r   <= SIDE_WDATA[2];
            end
            // Output enable cannot be set while shutdown is held low.
            if (!SHUTDOWN_N)
                out_en_r <= 1'b0;
            else if (OUT_EN_WR)
                out_en_r <= OUT_EN_WDATA;
            hiz_r  <= !SHUTDOWN_N && cutoff_r;
            gpio_r <= !SHUTDOWN_N && !cutoff_r;
        end
    end

    assign COUNT_RDATA  = rd_r;
    assign MODE_RDATA   = mode_r;
    assign SIDE_RDATA   = {cutoff_r, trig_sel_r, trig_en_r};
    assign RESULT_VALID = seen2_r;
    assign IRQ          = irq_r;
    assign ADC_START    = adc_r;
    assign RUNNING      = run_r;
    assign OUT_EN       = out_en_r;
    assign PHASE_HIZ    = hiz_r;
    assign PHASE_GPIO   = gpio_r;
endmodule
`default_nettype wire

/* File: pmt_monitor.sv */
// Port-level checker for the timer channel, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module pmt_monitor
(
    input wire logic       CLOCK,       // Clock.
    input wire logic       RST_N,       // Reset, active low.
    input wire logic [2:0] COUNT_START, // Start flags.
    input wire logic [1:0] CHAN_INDEX,  // Our flag.
    input wire logic       PROTECT_REL, // Write release.
    input wire logic       SIDE_WR,     // Side write.
    input wire logic [2:0] SIDE_WDATA,  // Side data.
    input wire logic       SHUTDOWN_N,  // Shutdown.
    input wire logic [7:0] MODE_RDATA,  // Mode read.
    input wire logic [2:0] SIDE_RDATA,  // Side read.
    input wire logic       IRQ,         // Interrupt.
    input wire logic       ADC_START,   // Conversion start.
    input wire logic       RUNNING,     // Count on.
    input wire logic       OUT_EN,      // Output enable.
    input wire logic       PHASE_HIZ,   // Pins hi-z.
    input wire logic       PHASE_GPIO   // Pins as I/O.
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////////
    a_adc_with_irq: assert property (ADC_START |-> IRQ)
        else $error("conversion start without interrupt");
    a_adc_ends_run: assert property (ADC_START |-> !RUNNING)
        else $error("count still running at conversion start");
    a_adc_trig_mode: assert property (ADC_START |-> MODE_RDATA[1:0] == 2'h3)
        else $error("conversion start outside trigger mode");
    a_side_locked: assert property (SIDE_WR && !PROTECT_REL |=> $stable(SIDE_RDATA))
        else $error("side control changed while protected");
    a_side_written: assert property (SIDE_WR && PROTECT_REL |=> SIDE_RDATA == $past(SIDE_WDATA))
        else $error("side control write lost");
    a_shutdown_off: assert property (!SHUTDOWN_N [*2] |-> !OUT_EN)
        else $error("output enable kept during shutdown");
    a_cutoff_hiz: assert property ((!SHUTDOWN_N && SIDE_RDATA[2]) [*2] |-> PHASE_HIZ && !PHASE_GPIO)
        else $error("pins not cut off");
    a_no_cutoff_io: assert property ((!SHUTDOWN_N && !SIDE_RDATA[2]) [*2] |-> PHASE_GPIO && !PHASE_HIZ)
        else $error("pins not returned to general I/O");
    a_run_needs_en: assert property ($rose(RUNNING) |-> $past(SIDE_RDATA[0]) && $past(COUNT_START[CHAN_INDEX]))
        else $error("trigger count started without enable");
    a_ovf_irq: assert property ($rose(MODE_RDATA[3]) |-> IRQ)
        else $error("overflow flag without interrupt");
    c_adc: cover property (ADC_START);
    c_ovf: cover property ($rose(MODE_RDATA[3]));
    c_hiz: cover property (!SHUTDOWN_N && PHASE_HIZ);
endmodule
bind pmt_top pmt_monitor mon_u (.*);
`default_nettype wire

/* File: pmt_far_side.sv */
// Behavioural far side: a square-wave pulse source and a conversion counter.
`timescale 1ns/10ps
`default_nettype none
module pmt_far_side
#(
    parameter int HALF = 128    // Half period in cycles.
)
(
    input  wire logic clk,       // Clock.
    input  wire logic en,        // Source runs while high.
    input  wire logic adc_start, // Conversion start pulse.
    output logic      pulse,     // Square wave to the channel.
    output int        conv_cnt   // Conversions started.
);
    int ph_r = 0;
    initial conv_cnt = 0;
    // Idles low between bursts, so every burst opens with a rising edge.
    always @(posedge clk)
    begin
        ph_r <= (en && ph_r < HALF - 1) ? ph_r + 1 : 0;
        if (!en)
            pulse <= 1'b0;
        else if (ph_r == HALF - 1)
            pulse <= ~pulse;
    end
    always @(posedge clk)
        if (adc_start === 1'b1)
            conv_cnt <= conv_cnt + 1;
endmodule
`default_nettype wire

/* File: pulse_measure_adc_trigger_timer_bench.sv */
// Self-checking bench for the pulse measurement and A/D trigger channel.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, e); end end
module pulse_measure_adc_trigger_timer_bench;
    logic        CLOCK, RST_N, MODE_WR, COUNT_WR, SUB_TICK, USE_SUBCLOCK, CH2_OVF_UDF, IRQ_FREQ_UDF, PROTECT_REL;
    logic        SIDE_WR, OUT_EN_WR, OUT_EN_WDATA, SHUTDOWN_N, MEASURE_PULSE, src_en, RESULT_VALID, IRQ;
    logic        ADC_START, RUNNING, OUT_EN, PHASE_HIZ, PHASE_GPIO;
    logic [2:0]  COUNT_START, SIDE_WDATA, SIDE_RDATA;
    logic [1:0]  CHAN_INDEX;
    logic [7:0]  MODE_WDATA, MODE_RDATA;
    logic [15:0] COUNT_WDATA, COUNT_RDATA;
    int          n_mismatch, comparisons, conv, l1, l2;
    time         t_adc;
    pmt_top dut_u (.*);
    pmt_far_side far_u (.clk(CLOCK), .en(src_en), .adc_start(ADC_START), .pulse(MEASURE_PULSE), .conv_cnt(conv));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    // Subclock tick every 64 cycles, so that source runs at half the rate of f32.
    initial
    begin
        SUB_TICK = 1'b0;
        forever
        begin
            repeat (63) @(posedge CLOCK);
            #1 SUB_TICK = 1'b1;
            @(posedge CLOCK);
            #1 SUB_TICK = 1'b0;
        end
    end
    always @(posedge CLOCK)
        if (ADC_START === 1'b1)
            t_adc = $time;
    initial
    begin
        repeat (90000) @(posedge CLOCK);
        n_mismatch++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    // A strobe stands one edge, then one idle edge so calls may follow back to back.
    task automatic pulse_on(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask
    task automatic side(input logic p, input logic [2:0] d);
        PROTECT_REL = p;
        SIDE_WDATA = d;
        pulse_on(SIDE_WR);
    endtask
    task automatic adt(input logic [15:0] n, input logic [15:0] w, input logic r, output int lat);
        int c0;
        time t0;
        COUNT_WDATA = n;
        pulse_on(COUNT_WR);
        c0 = conv;
        t0 = $time;
        pulse_on(CH2_OVF_UDF);
        COUNT_WDATA = w;
        pulse_on(COUNT_WR);
        if (r)
            pulse_on(CH2_OVF_UDF);
        tick(40);
        lat = int'((t_adc - t0) / 40);
        `CHK(COUNT_RDATA, w)
        `CHK(conv, c0 + 1)
    endtask
    task automatic trg(ref logic t, input logic e);
        pulse_on(t);
        `CHK(RUNNING, e)
        tick(120);
    endtask
    task automatic meas(input logic [7:0] m, input logic sub, input logic [15:0] e, input int ei);
        int irqs;
        logic [15:0] v;
        src_en = 1'b0;
        USE_SUBCLOCK = sub;
        MODE_WDATA = m;
        pulse_on(MODE_WR);
        COUNT_START = 3'h1;
        src_en = 1'b1;
        irqs = 0;
        for (int i = 0; i < 700; i++)
        begin
            tick();
            irqs += (IRQ === 1'b1);
            // Only the first edge has been taken at this point, in every mode used.
            if (i == 200)
                `CHK(RESULT_VALID, 1'b0)
        end
        `CHK(RESULT_VALID, 1'b1)
        v = COUNT_RDATA;
        COUNT_START = 3'h0;
        `CHK(irqs, ei)
        `CHK(v + 16'h1 - e <= 16'h2, 1'b1)
        COUNT_WDATA = 16'h1234;
        pulse_on(COUNT_WR);
        `CHK(COUNT_RDATA, v)
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {COUNT_START, CHAN_INDEX, MODE_WR, MODE_WDATA, COUNT_WR, COUNT_WDATA, USE_SUBCLOCK} = '0;
        {CH2_OVF_UDF, IRQ_FREQ_UDF, PROTECT_REL, SIDE_WR, SIDE_WDATA, OUT_EN_WR, OUT_EN_WDATA, src_en, RST_N} = '0;
        SHUTDOWN_N = 1'b1;
        tick(12);
        RST_N = 1'b1;
        `CHK({MODE_RDATA, SIDE_RDATA, COUNT_RDATA}, 27'h0)
        for (int k = 0; k < 4; k++)
        begin
            MODE_WDATA = 8'(k);
            pulse_on(MODE_WR);
            `CHK(MODE_RDATA[1:0], k[1:0])
        end
        side(1'b1, 3'h1);
        COUNT_START = 3'h1;
        adt(16'h2, 16'h2, 1'b0, l1);
        // The second run holds a count 4 larger, so its conversion comes 4 cycles later.
        adt(16'h6, 16'h6, 1'b0, l2);
        `CHK(l2 - l1, 4)
        adt(16'h6, 16'h9, 1'b1, l1);
        `CHK(l1, l2)
        side(1'b0, 3'h0);
        `CHK(SIDE_RDATA, 3'h1)
        COUNT_WDATA = 16'h0064;
        pulse_on(COUNT_WR);
        trg(CH2_OVF_UDF, 1'b1);
        trg(IRQ_FREQ_UDF, 1'b0);
        // Frequency-counter triggers assume a system with the three-phase function on.
        side(1'b1, 3'h3);
        trg(CH2_OVF_UDF, 1'b0);
        trg(IRQ_FREQ_UDF, 1'b1);
        side(1'b1, 3'h2);
        trg(IRQ_FREQ_UDF, 1'b0);
        side(1'b1, 3'h3);
        COUNT_START = 3'h2;
        trg(IRQ_FREQ_UDF, 1'b0);
        CHAN_INDEX = 2'h1;
        trg(IRQ_FREQ_UDF, 1'b1);
        CHAN_INDEX = 2'h0;
        OUT_EN_WDATA = 1'b1;
        pulse_on(OUT_EN_WR);
        `CHK(OUT_EN, 1'b1)
        SHUTDOWN_N = 1'b0;
        pulse_on(OUT_EN_WR);
        `CHK({OUT_EN, PHASE_GPIO, PHASE_HIZ}, 3'b010)
        side(1'b1, 3'h4);
        `CHK({OUT_EN, PHASE_GPIO, PHASE_HIZ}, 3'b001)
        SHUTDOWN_N = 1'b1;
        meas(8'hc2, 1'b0, 16'h0008, 2);
        meas(8'h82, 1'b0, 16'h0020, 2);
        meas(8'h42, 1'b0, 16'h0080, 2);
        meas(8'h02, 1'b1, 16'h0004, 2);
        meas(8'h06, 1'b0, 16'h0080, 4);
        meas(8'h02, 1'b0, 16'h0100, 2);
        src_en = 1'b0;
        COUNT_START = 3'h1;
        for (int i = 0; i < 70000 && MODE_RDATA[3] !== 1'b1; i++)
            tick();
        `CHK(MODE_RDATA[3], 1'b1)
        tick(2);
        pulse_on(MODE_WR);
        `CHK(MODE_RDATA[3], 1'b0)
        final_report();
    end
endmodule
`default_nettype wire
